// ---- sram_port_pkg.sv ----
package sram_port_pkg;

    localparam int ADDR_W_DEF = 18;
    localparam int LANES_DEF  = 4;
    localparam int BYTE_W     = 8;
    localparam int LANE_W     = 9;

    localparam int BURST_LEN = 4;
    localparam logic [1:0] BURST_IDX_RESET = 2'h0;
    localparam logic [1:0] BURST_IDX_STEP  = 2'h1;

    // Sleep entry and exit, counted in core_clk cycles
    localparam logic [1:0] SLEEP_ENTRY_CYCLES = 2'h2;
    localparam logic [1:0] SLEEP_EXIT_CYCLES  = 2'h2;
    localparam logic [1:0] SLEEP_ENTRY_LAST   = SLEEP_ENTRY_CYCLES - 2'h1;
    localparam logic [1:0] SLEEP_EXIT_LAST    = SLEEP_EXIT_CYCLES - 2'h1;
    localparam logic [1:0] SLEEP_CNT_RESET    = 2'h0;

    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_READ  = 2'b01,
        OP_WRITE = 2'b10
    } op_t;

    typedef enum logic [1:0] {
        SLP_AWAKE  = 2'b00,
        SLP_ENTER  = 2'b01,
        SLP_ASLEEP = 2'b10,
        SLP_EXIT   = 2'b11
    } sleep_t;

endpackage

// ---- sram_mem_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface sram_mem_if #(
    parameter int ADDR_W = sram_port_pkg::ADDR_W_DEF,
    parameter int LANES  = sram_port_pkg::LANES_DEF
);
    localparam int WORD_W = LANES * sram_port_pkg::LANE_W;

    logic              rdEn;
    logic [ADDR_W-1:0] rdAddr;
    logic [WORD_W-1:0] rdData;
    logic              wrEn;
    logic [ADDR_W-1:0] wrAddr;
    logic [LANES-1:0]  wrLanes;
    logic [WORD_W-1:0] wrData;

    modport ctrl (output rdEn, rdAddr, wrEn, wrAddr, wrLanes, wrData,
                  input rdData);
    modport mem  (input rdEn, rdAddr, wrEn, wrAddr, wrLanes, wrData,
                  output rdData);
endinterface
`default_nettype wire

// ---- burst_addr_seq.sv ----
`timescale 1ns/10ps
`default_nettype none
module burst_addr_seq (
    input  wire logic [1:0] startLow,
    input  wire logic [1:0] index,
    input  wire logic       interleaved,
    output logic      [1:0] seqLow
);
    // Only the two low address bits move; both orders wrap in the group
    assign seqLow = interleaved ? (startLow ^ index)          // R23 R10
                                : 2'(startLow + index);      // R24 R10
endmodule
`default_nettype wire

// ---- sram_word_mem.sv ----
`timescale 1ns/10ps
`default_nettype none
module sram_word_mem #(
    parameter int ADDR_W = sram_port_pkg::ADDR_W_DEF,
    parameter int LANES  = sram_port_pkg::LANES_DEF
) (
    input  wire logic clk,
    input  wire logic rst_n,
    sram_mem_if.mem   port
);
    localparam int LW     = sram_port_pkg::LANE_W;
    localparam int WORD_W = LANES * LW;

    logic [WORD_W-1:0] store [2**ADDR_W];
    logic [WORD_W-1:0] rdData;
    logic [WORD_W-1:0] next_rdData;
    logic              sameAddr;

    // No reset on the array: contents survive reset and sleep
    always_ff @(posedge clk) begin
        for (int l = 0; l < LANES; l++) begin
            if (port.wrEn && port.wrLanes[l]) begin
                store[port.wrAddr][l*LW +: LW] <= port.wrData[l*LW +: LW];
            end
        end
    end

    // Read and write of one word on the same edge: new lanes win
    always_comb begin
        next_rdData = rdData;
        sameAddr    = port.wrEn && (port.wrAddr == port.rdAddr);
        if (port.rdEn) begin
            for (int l = 0; l < LANES; l++) begin
                if (sameAddr && port.wrLanes[l]) begin
                    next_rdData[l*LW +: LW] = port.wrData[l*LW +: LW];
                end else begin
                    next_rdData[l*LW +: LW] = store[port.rdAddr][l*LW +: LW];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= '0;
        end else begin
            rdData <= next_rdData;
        end
    end

    assign port.rdData = rdData;
endmodule
`default_nettype wire

// ---- pipelined_burst_sram_port.sv ----
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1: Unqualified clock edge changes no state; sleep sequencing and kill still run on it.
// R2: Qualified selected load captures the address.
// R3: Read starts on selected load, strobe high.
// R4: Read word enters output register next edge.
// R5: Data drives only with output enable low.
// R6: New command accepted right after read address.
// R7: Deselect floats outputs after the following edge.
// R8: Burst counter runs four accesses per address.
// R9: Order strap low linear, high interleaved.
// R10: Counter touches two low bits, wraps.
// R11: Advance high increments, ignores selects and strobe.
// R12: Burst keeps direction captured at its start.
// R13: Write starts on selected load, strobe low.
// R14: Outputs float the edge after write address.
// R15: Write data taken second edge after address.
// R16: Only enabled byte lanes with parity change.
// R17: Controller avoids driving while outputs active.
// R18: Controller drives lane enables each burst cycle.
// R19: Controller loads fresh address after deselect.
// R20: Sleep entry and exit take two cycles.
// R21: Access pending at sleep entry is dropped.
// R22: Controller deselects around sleep and recovery.
// R23: Interleaved order XORs start with index.
// R24: Linear order adds index, wraps 11 to 00.
// R25: Reset leaves device deselected, outputs floating.
// R26: Stall keeps output register driving.
module pipelined_burst_sram_port #(
    parameter int ADDR_W = sram_port_pkg::ADDR_W_DEF,
    parameter int LANES  = sram_port_pkg::LANES_DEF
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic                  clock_qualify_n,
    input  wire logic                  chip_select_one_n,
    input  wire logic                  chip_select_two,
    input  wire logic                  chip_select_three_n,
    input  wire logic                  advance_or_load,
    input  wire logic                  write_strobe_n,
    input  wire logic [LANES-1:0]      byte_lane_write_n,
    input  wire logic [ADDR_W-1:0]     address,
    input  wire logic                  burst_order,
    input  wire logic                  output_drive_enable_n,
    input  wire logic                  sleep_request,
    input  wire logic [LANES*8-1:0]    dataIn,
    input  wire logic [LANES-1:0]      parityIn,
    output logic      [LANES*8-1:0]    dataOut,
    output logic      [LANES-1:0]      parityOut,
    output logic                       dataOe
);
    localparam int DW = sram_port_pkg::BYTE_W;
    localparam int LW = sram_port_pkg::LANE_W;

    if (ADDR_W < 2 || ADDR_W > 24 || LANES < 1 || LANES > 8
        || DW != 8) begin : g_param_check
        $error("Unsupported address width or lane count");
    end

    sram_port_pkg::sleep_t sleepState;
    sram_port_pkg::sleep_t next_sleepState;
    logic [1:0]            sleepCnt;
    logic [1:0]            next_sleepCnt;

    logic                  qualified;
    logic                  allSelected;
    logic                  kill;
    logic                  step;
    logic                  readStart;
    logic                  writeStart;
    logic [ADDR_W-1:0]     loadAddr;
    logic [ADDR_W-1:0]     next_loadAddr;
    logic [1:0]            burstIdx;
    logic [1:0]            next_burstIdx;
    logic [1:0]            stepIdx;
    logic [1:0]            seqLow;
    logic [1:0]            linExpect;
    logic                  burstWrite;
    logic                  next_burstWrite;
    logic                  burstActive;
    logic                  next_burstActive;
    sram_port_pkg::op_t    s1Op;
    sram_port_pkg::op_t    next_s1Op;
    logic [ADDR_W-1:0]     s1Addr;
    logic [ADDR_W-1:0]     next_s1Addr;
    logic [LANES-1:0]      s1Lanes;
    logic [LANES-1:0]      next_s1Lanes;
    sram_port_pkg::op_t    s2Op;
    sram_port_pkg::op_t    next_s2Op;
    logic [ADDR_W-1:0]     s2Addr;
    logic [ADDR_W-1:0]     next_s2Addr;
    logic [LANES-1:0]      s2Lanes;
    logic [LANES-1:0]      next_s2Lanes;
    logic                  driveRead;
    logic                  next_driveRead;

    sram_mem_if #(.ADDR_W(ADDR_W), .LANES(LANES)) memPort ();

    function automatic sram_port_pkg::op_t dirToOp(input logic isWrite);
        return isWrite ? sram_port_pkg::OP_WRITE : sram_port_pkg::OP_READ;
    endfunction

    assign qualified   = !clock_qualify_n;
    assign allSelected = !chip_select_one_n && chip_select_two
                         && !chip_select_three_n;
    // A pending access is abandoned as soon as sleep is requested
    assign kill        = (sleepState != sram_port_pkg::SLP_AWAKE)
                         || sleep_request;
    assign step        = qualified && !kill;
    assign readStart   = step && !advance_or_load && allSelected
                         && write_strobe_n;
    assign writeStart  = step && !advance_or_load && allSelected
                         && !write_strobe_n;
    assign stepIdx     = burstIdx + sram_port_pkg::BURST_IDX_STEP;
    assign linExpect   = 2'(loadAddr[1:0] + stepIdx);

    burst_addr_seq u_seq (
        .startLow    (loadAddr[1:0]),
        .index       (stepIdx),
        .interleaved (burst_order),                                   // R9
        .seqLow      (seqLow)
    );

    // Sleep sequencing runs on every edge, qualified or not
    always_comb begin
        next_sleepState = sleepState;
        next_sleepCnt   = sleepCnt;
        case (sleepState)
            sram_port_pkg::SLP_AWAKE: begin
                if (sleep_request) begin
                    next_sleepState = sram_port_pkg::SLP_ENTER;       // R20
                    next_sleepCnt   = sram_port_pkg::SLEEP_CNT_RESET;
                end
            end
            sram_port_pkg::SLP_ENTER: begin
                if (sleepCnt == sram_port_pkg::SLEEP_ENTRY_LAST) begin
                    next_sleepState = sram_port_pkg::SLP_ASLEEP;      // R20
                end else begin
                    next_sleepCnt = sleepCnt + 2'h1;
                end
            end
            sram_port_pkg::SLP_ASLEEP: begin
                if (!sleep_request) begin
                    next_sleepState = sram_port_pkg::SLP_EXIT;
                    next_sleepCnt   = sram_port_pkg::SLEEP_CNT_RESET;
                end
            end
            sram_port_pkg::SLP_EXIT: begin
                if (sleepCnt == sram_port_pkg::SLEEP_EXIT_LAST) begin
                    next_sleepState = sram_port_pkg::SLP_AWAKE;       // R20
                end else begin
                    next_sleepCnt = sleepCnt + 2'h1;
                end
            end
            default: begin
                next_sleepState = sram_port_pkg::SLP_AWAKE;
                next_sleepCnt   = sram_port_pkg::SLEEP_CNT_RESET;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleepState <= sram_port_pkg::SLP_AWAKE;
            sleepCnt   <= sram_port_pkg::SLEEP_CNT_RESET;
        end else begin
            sleepState <= next_sleepState;
            sleepCnt   <= next_sleepCnt;
        end
    end

    // Command pipeline: stage 1 holds the addressed access, stage 2
    // holds the write waiting for its data and the read being driven
    always_comb begin
        next_loadAddr    = loadAddr;
        next_burstIdx    = burstIdx;
        next_burstWrite  = burstWrite;
        next_burstActive = burstActive;
        next_s1Op        = s1Op;
        next_s1Addr      = s1Addr;
        next_s1Lanes     = s1Lanes;
        next_s2Op        = s2Op;
        next_s2Addr      = s2Addr;
        next_s2Lanes     = s2Lanes;
        next_driveRead   = driveRead;
        if (kill) begin
            next_burstActive = 1'b0;                                  // R21
            next_s1Op        = sram_port_pkg::OP_IDLE;                // R21
            next_s2Op        = sram_port_pkg::OP_IDLE;
            next_driveRead   = 1'b0;
        end else if (qualified) begin                                 // R1
            next_s2Op      = s1Op;
            next_s2Addr    = s1Addr;
            next_s2Lanes   = s1Lanes;
            // Outputs follow stage 1 one edge later; a write floats them
            next_driveRead = (s1Op == sram_port_pkg::OP_READ);        // R14
            next_s1Lanes   = ~byte_lane_write_n;
            if (advance_or_load) begin
                if (burstActive) begin                                // R11
                    next_burstIdx = stepIdx;                          // R8
                    next_s1Op     = dirToOp(burstWrite);              // R12
                    next_s1Addr   = {loadAddr[ADDR_W-1:2], seqLow};   // R10
                end else begin
                    next_s1Op = sram_port_pkg::OP_IDLE;
                end
            end else if (allSelected) begin                           // R6
                next_loadAddr    = address;                           // R2
                next_burstIdx    = sram_port_pkg::BURST_IDX_RESET;
                next_burstWrite  = !write_strobe_n;                   // R12
                next_burstActive = 1'b1;
                next_s1Op        = dirToOp(!write_strobe_n);          // R3 R13
                next_s1Addr      = address;
            end else begin
                next_burstActive = 1'b0;                              // R7
                next_s1Op        = sram_port_pkg::OP_IDLE;            // R7
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            loadAddr    <= '0;
            burstIdx    <= sram_port_pkg::BURST_IDX_RESET;
            burstWrite  <= 1'b0;
            burstActive <= 1'b0;
            s1Op        <= sram_port_pkg::OP_IDLE;                    // R25
            s1Addr      <= '0;
            s1Lanes     <= '0;
            s2Op        <= sram_port_pkg::OP_IDLE;
            s2Addr      <= '0;
            s2Lanes     <= '0;
            driveRead   <= 1'b0;                                      // R25
        end else begin
            loadAddr    <= next_loadAddr;
            burstIdx    <= next_burstIdx;
            burstWrite  <= next_burstWrite;
            burstActive <= next_burstActive;
            s1Op        <= next_s1Op;
            s1Addr      <= next_s1Addr;
            s1Lanes     <= next_s1Lanes;
            s2Op        <= next_s2Op;
            s2Addr      <= next_s2Addr;
            s2Lanes     <= next_s2Lanes;
            driveRead   <= next_driveRead;
        end
    end

    assign memPort.rdEn    = step && (s1Op == sram_port_pkg::OP_READ); // R4
    assign memPort.rdAddr  = s1Addr;
    assign memPort.wrEn    = step && (s2Op == sram_port_pkg::OP_WRITE);// R15
    assign memPort.wrAddr  = s2Addr;
    assign memPort.wrLanes = s2Lanes;                                 // R16

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        assign memPort.wrData[l*LW +: LW] = {parityIn[l],
                                             dataIn[l*DW +: DW]};
        assign dataOut[l*DW +: DW] = memPort.rdData[l*LW +: DW];
        assign parityOut[l]        = memPort.rdData[l*LW + DW];
    end

    sram_word_mem #(.ADDR_W(ADDR_W), .LANES(LANES)) u_mem (
        .clk   (core_clk),
        .rst_n (rst_n),
        .port  (memPort)
    );

    // Output register holds through stalls, so drive continues
    assign dataOe = driveRead && !output_drive_enable_n;             // R5 R26

    stall_hold_a: assert property (  // R1
        @(posedge core_clk) disable iff (!rst_n)
        (clock_qualify_n && !kill) |=> ($stable(loadAddr)
            && $stable(s1Op) && $stable(burstIdx) && $stable(dataOut)))
        else $error("State changed on a stalled edge");

    addr_load_a: assert property (  // R2
        @(posedge core_clk) disable iff (!rst_n)
        (step && !advance_or_load && allSelected)
            |=> (loadAddr == $past(address)))
        else $error("Address not captured on load");

    read_pipe_a: assert property (  // R4
        @(posedge core_clk) disable iff (!rst_n)
        readStart ##1 step |=> (driveRead && s2Op == sram_port_pkg::OP_READ))
        else $error("Read data not in output register");

    drive_gate_a: assert property (  // R5
        @(posedge core_clk) disable iff (!rst_n)
        dataOe |-> (!output_drive_enable_n && s2Op != sram_port_pkg::OP_WRITE))
        else $error("Data driven without output enable");

    desel_float_a: assert property (  // R7
        @(posedge core_clk) disable iff (!rst_n)
        (step && !advance_or_load && !allSelected) ##1 step |=> !dataOe)
        else $error("Outputs not floated after deselect");

    write_float_a: assert property (  // R14
        @(posedge core_clk) disable iff (!rst_n)
        writeStart ##1 step |=> !dataOe)
        else $error("Outputs driven during write data cycle");

    write_commit_a: assert property (  // R15
        @(posedge core_clk) disable iff (!rst_n)
        writeStart ##1 step ##1 step
            |-> (memPort.wrEn && memPort.wrAddr == $past(address, 2)))
        else $error("Write not committed on second edge");

    burst_linear_a: assert property (  // R24
        @(posedge core_clk) disable iff (!rst_n)
        (step && advance_or_load && burstActive && !burst_order)
            |=> (s1Addr[1:0] == $past(linExpect)))
        else $error("Linear burst address wrong");

    burst_dir_a: assert property (  // R12
        @(posedge core_clk) disable iff (!rst_n)
        (step && advance_or_load && burstActive && burstWrite)
            |=> (s1Op == sram_port_pkg::OP_WRITE))
        else $error("Burst changed direction");

    sleep_entry_a: assert property (  // R20
        @(posedge core_clk) disable iff (!rst_n)
        (sleepState == sram_port_pkg::SLP_AWAKE && sleep_request)
            |=> (sleepState == sram_port_pkg::SLP_ENTER) [*2]
            ##1 (sleepState == sram_port_pkg::SLP_ASLEEP))
        else $error("Sleep entry not two cycles");

    sleep_exit_a: assert property (  // R20
        @(posedge core_clk) disable iff (!rst_n)
        (sleepState == sram_port_pkg::SLP_ASLEEP && !sleep_request)
            |=> (sleepState == sram_port_pkg::SLP_EXIT) [*2]
            ##1 (sleepState == sram_port_pkg::SLP_AWAKE))
        else $error("Sleep exit not two cycles");

    sleep_kill_a: assert property (  // R21
        @(posedge core_clk) disable iff (!rst_n)
        kill |=> (s1Op == sram_port_pkg::OP_IDLE && !dataOe))
        else $error("Access survived sleep entry");

endmodule
`default_nettype wire

// ---- sram_ctrl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module sram_ctrl_model (
    input  wire logic        clk,
    output logic             qualN,
    output logic             sel1N,
    output logic             sel2,
    output logic             sel3N,
    output logic             advLd,
    output logic             weN,
    output logic [3:0]       lanesN,
    output logic [17:0]      addr,
    output logic             order,
    output logic             oeN,
    output logic             sleepReq,
    output logic [35:0]      wrWord
);
    logic [36:0] p1;
    logic [36:0] p2;
    logic        burstW;

    initial begin
        {qualN, sel1N, sel2, sel3N, advLd, weN} = 6'h15;
        lanesN = 4'hf;
        addr = 18'h0_0000;
        {order, oeN, sleepReq} = 3'h0;
        wrWord = 36'h0_0000_0000;
        p1 = 37'h00_0000_0000;
        p2 = 37'h00_0000_0000;
        burstW = 1'b0;
    end

    // Kind 0 deselect, 1 read, 2 write, 3 advance
    task automatic op(input logic [1:0] k, input logic [17:0] a,
                      input logic [3:0] ln, input logic [35:0] wd);
        @(negedge clk);
        qualN = 1'b0;
        advLd = (k == 2'h3);
        if (k != 2'h3) begin
            burstW = (k == 2'h2);
        end
        {sel1N, sel2, sel3N} = (k[0] ^ k[1]) ? 3'h2 : 3'h5;
        weN = (k == 2'h3) ? burstW : (k != 2'h2);
        lanesN = ln;
        addr = a;
        // Undriven bus toggles so a stale word never looks valid
        wrWord = p2[36] ? p2[35:0] : ~wrWord;
        p2 = p1;
        p1 = {k[1] & burstW, wd};
    endtask

    // Called at a falling edge, right after op or stall returns
    task automatic pins(input logic ord, input logic oe, input logic slp);
        order    = ord;
        oeN      = oe;
        sleepReq = slp;
    endtask

    task automatic stall();
        @(negedge clk);
        qualN = 1'b1;
        wrWord = ~wrWord;
    endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [1:0] DSEL = 2'h0;
    localparam logic [1:0] RD   = 2'h1;
    localparam logic [1:0] WR   = 2'h2;
    localparam logic [1:0] ADV  = 2'h3;
    localparam int         WATCH_NS = 20000;
    logic        clk;
    logic        rstN;
    logic        qualN, sel1N, sel2, sel3N, advLd, weN, order, oeN;
    logic        sleepReq;
    logic [3:0]  lanesN;
    logic [17:0] addr;
    logic [35:0] wrWord;
    logic [31:0] dataOut;
    logic [3:0]  parityOut;
    logic        dataOe;
    int          bad_count;
    int          comparisons;
    logic [35:0] shadow [int];

    always #4 clk = ~clk;

    sram_ctrl_model ctrl_u (
        .clk(clk), .qualN(qualN), .sel1N(sel1N), .sel2(sel2),
        .sel3N(sel3N), .advLd(advLd), .weN(weN), .lanesN(lanesN),
        .addr(addr), .order(order), .oeN(oeN), .sleepReq(sleepReq),
        .wrWord(wrWord)
    );

    pipelined_burst_sram_port dut_u (
        .core_clk(clk), .rst_n(rstN), .clock_qualify_n(qualN),
        .chip_select_one_n(sel1N), .chip_select_two(sel2),
        .chip_select_three_n(sel3N), .advance_or_load(advLd),
        .write_strobe_n(weN), .byte_lane_write_n(lanesN),
        .address(addr), .burst_order(order),
        .output_drive_enable_n(oeN), .sleep_request(sleepReq),
        .dataIn(wrWord[31:0]), .parityIn(wrWord[35:32]),
        .dataOut(dataOut), .parityOut(parityOut), .dataOe(dataOe)
    );

    task automatic chkW(input logic [35:0] exp);
        comparisons++;
        if ({parityOut, dataOut} !== exp) begin
            bad_count++;
            $display("unexpected at %0t: word %h not %h", $time,
                     {parityOut, dataOut}, exp);
        end
    endtask

    task automatic chkOe(input logic exp);
        comparisons++;
        if (dataOe !== exp) begin
            bad_count++;
            $display("unexpected at %0t: drive %b not %b", $time,
                     dataOe, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) ctrl_u.op(DSEL, 18'h0_0000, 4'hf, 36'h0_0000_0000);
    endtask

    task automatic rd(input logic [17:0] a);
        ctrl_u.op(RD, a, 4'hf, 36'h0_0000_0000);
    endtask

    task automatic testReset();
        chkOe(1'b0);
        chkW(36'h0_0000_0000);
        $display("test reset done");
    endtask

    // Same-edge read of a landing write relies on forwarding
    task automatic testBackToBack();
        rd(18'h0_0020);
        ctrl_u.op(WR, 18'h0_0010, 4'h0, 36'h1_2345_6789);
        shadow[16] = 36'h1_2345_6789;
        ctrl_u.op(WR, 18'h0_0020, 4'h0, 36'h2_abcd_ef01);
        shadow[32] = 36'h2_abcd_ef01;
        chkOe(1'b1);
        rd(18'h0_0020);
        chkOe(1'b0);
        rd(18'h0_0010);
        idle(1);
        chkW(shadow[32]);
        idle(1);
        chkW(shadow[16]);
        idle(1);
        chkOe(1'b0);
        $display("test back_to_back done");
    endtask

    task automatic testLanes();
        ctrl_u.op(WR, 18'h0_0030, 4'h0, 36'h0_1111_2222);
        ctrl_u.op(WR, 18'h0_0030, 4'h5, 36'hf_aaaa_bbbb);
        idle(2);
        rd(18'h0_0030);
        idle(2);
        chkW(36'ha_aa11_bb22);
        $display("test lanes done");
    endtask

    task automatic testStall();
        rd(18'h0_0030);
        idle(1);
        repeat (3) begin
            ctrl_u.stall();
            chkOe(1'b1);
            chkW(36'ha_aa11_bb22);
        end
        ctrl_u.pins(1'b0, 1'b1, 1'b0);
        #1 chkOe(1'b0);
        ctrl_u.stall();
        ctrl_u.pins(1'b0, 1'b0, 1'b0);
        #1 chkOe(1'b1);
        idle(2);
        chkOe(1'b0);
        $display("test stall done");
    endtask

    task automatic testBurst();
        ctrl_u.pins(1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            ctrl_u.op(i == 0 ? WR : ADV, 18'h0_0101, 4'h0,
                      36'h9_5555_0000 + 36'(i));
            shadow[{16'h0040, 2'(i + 1)}] = 36'h9_5555_0000 + 36'(i);
        end
        idle(3);
        ctrl_u.pins(1'b1, 1'b0, 1'b0);
        for (int i = 0; i < 6; i++) begin
            ctrl_u.op(i == 0 ? RD : (i < 4 ? ADV : DSEL), 18'h0_0102,
                      4'hf, 36'h0_0000_0000);
            if (i >= 2) chkW(shadow[{16'h0040, 2'h2 ^ 2'(i - 2)}]);
        end
        $display("test burst done");
    endtask

    task automatic testSleep();
        idle(1);
        ctrl_u.pins(1'b1, 1'b0, 1'b1);
        idle(3);
        rd(18'h0_0010);
        idle(2);
        chkOe(1'b0);
        ctrl_u.pins(1'b1, 1'b0, 1'b0);
        idle(4);
        rd(18'h0_0010);
        idle(2);
        chkW(shadow[16]);
        chkOe(1'b1);
        $display("test sleep done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        rstN = 1'b0;
        bad_count = 0;
        comparisons = 0;
        repeat (4) @(negedge clk);
        rstN = 1'b1;
        testReset();
        testBackToBack();
        testLanes();
        testStall();
        testBurst();
        testSleep();
        print_verdict();
    end

    // Whole run is under a hundred cycles
    initial begin
        #(WATCH_NS);
        $display("unexpected at %0t: watchdog expired", $time);
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
